// [rtl/ptc_consts.svh]
// Constants for the paired 32-bit cascade timer
`ifndef PTC_CONSTS_SVH
`define PTC_CONSTS_SVH
// Control word field positions
`define PTC_CTL_ON      15
`define PTC_CTL_IDLE    13
`define PTC_CTL_GATE    6
`define PTC_CTL_PS_HI   5
`define PTC_CTL_PS_LO   4
`define PTC_CTL_CHAIN   3
`define PTC_CTL_SRC     1
// Reset values
`define PTC_CTL_RST     16'h0000
`define PTC_PER_RST     16'hffff
`define PTC_CNT_RST     16'h0000
`endif

// [rtl/ptc_pkg.sv]
// Types shared by the paired cascade timer
package ptc_pkg;
   // Decoded control word of one timer
   typedef struct packed {
      logic       on;
      logic       idle_stop;
      logic       gate_en;
      logic [1:0] prescale;
      logic       chain;
      logic       ext_src;
   } ptc_ctl_t;
   // Write strobes into one timer
   typedef struct packed {
      logic        cnt_we;
      logic        per_we;
      logic [15:0] wdata;
   } ptc_wr_t;
endpackage

// [rtl/ptc_prescale.sv]
// Prescaler and clock source selection for one timer
`timescale 1ns/1ns
`include "ptc_consts.svh"
module ptc_prescale (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   // Control
   input  wire logic       run,
   input  wire logic       ext_src,
   input  wire logic [1:0] prescale,
   // Count sources
   input  wire logic       ext_clk,
   input  wire logic       gate_in,
   input  wire logic       gate_en,
   // Count enable pulse
   output logic            tick
);
   logic [7:0] div_reg;
   logic       ext_d_reg;
   logic       raw;
   logic       hit;

   // External clock edge detect; inputs are taken as synchronous
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ext_d_reg <= 1'b0;
      end else begin
         ext_d_reg <= ext_clk;
      end
   end

   // Source pulse, then gate qualifies it
   assign raw = (ext_src ? (ext_clk & ~ext_d_reg) : 1'b1) & (~gate_en | gate_in);

   // Prescale 1, 8, 64, 256
   always_comb begin
      unique case (prescale)
         2'd0: hit = 1'b1;
         2'd1: hit = (div_reg[2:0] == 3'h7);
         2'd2: hit = (div_reg[5:0] == 6'h3f);
         2'd3: hit = (div_reg == 8'hff);
      endcase
   end

   // Divider held clear while stopped so restart is aligned
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !run) begin
         div_reg <= 8'h00;
      end else if (raw) begin
         div_reg <= div_reg + 8'h01;
      end
   end

   assign tick = run & raw & hit;
endmodule

// [rtl/ptc_timer_pair.sv]
// Paired 16-bit timers that can chain into one 32-bit timer
// Operation
// - Unchained, each 16-bit timer takes its mode from its own control word.
// - Chained: lower timer is low word, upper timer is high word.
// - Chained: upper control word ignored; lower control word sets up both.
// - Chained: lower timer clock source and gate drive the combined count.
// - Chained: match sets upper flag; only upper enable gates the request.
// - No conversion trigger output exists on this pair.
// - Neither timer offers a time base to other peripherals.
`timescale 1ns/1ns
`include "ptc_consts.svh"
module ptc_timer_pair
   import ptc_pkg::*;
(
   // Clock and reset
   input  wire logic            sys_clk,
   input  wire logic            sys_rst,
   input  wire logic            cpu_idle,
   // Control words
   input  wire logic [15:0]     lower_timer_control,
   input  wire logic [15:0]     upper_timer_control,
   // Counter and period writes
   input  wire ptc_pkg::ptc_wr_t lower_wr,
   input  wire ptc_pkg::ptc_wr_t upper_wr,
   // Clock and gate pins
   input  wire logic            lower_ext_clk,
   input  wire logic            lower_gate,
   input  wire logic            upper_ext_clk,
   input  wire logic            upper_gate,
   // Interrupt flag controls
   input  wire logic            lower_flag_clr,
   input  wire logic            pair_flag_clr,
   input  wire logic            lower_int_enable,
   input  wire logic            pair_interrupt_enable,
   // Counter values
   output logic [15:0]          lower_count,
   output logic [15:0]          upper_count,
   // Flags and requests
   output logic                 lower_flag,
   output logic                 pair_interrupt_flag,
   output logic                 lower_irq,
   output logic                 pair_irq
);
   import ptc_pkg::*;

   ptc_ctl_t    lc, uc;
   logic        chain;
   logic        l_run, u_run;
   logic        l_tick, u_tick;
   logic [15:0] l_cnt_reg, u_cnt_reg;
   logic [15:0] l_per_reg, u_per_reg;
   logic        l_match, u_match, m32;
   logic        l_flag_reg, u_flag_reg;
   logic        l_set, u_set;

   ///////////////////////////////////////////////////////////////////////
   // Decode both control words
   function automatic ptc_ctl_t dec(input logic [15:0] w);
      ptc_ctl_t c;
      c.on        = w[`PTC_CTL_ON];
      c.idle_stop = w[`PTC_CTL_IDLE];
      c.gate_en   = w[`PTC_CTL_GATE];
      c.prescale  = w[`PTC_CTL_PS_HI:`PTC_CTL_PS_LO];
      c.chain     = w[`PTC_CTL_CHAIN];
      c.ext_src   = w[`PTC_CTL_SRC];
      return c;
   endfunction

   assign lc    = dec(lower_timer_control);
   assign uc    = dec(upper_timer_control);
   assign chain = lc.chain;

   // Idle stop halts a timer only while the CPU idles
   assign l_run = lc.on & ~(lc.idle_stop & cpu_idle);
   // Chained: upper run held off; the upper word steps only from the lower timer
   assign u_run = chain ? 1'b0 : (uc.on & ~(uc.idle_stop & cpu_idle));

   ///////////////////////////////////////////////////////////////////////
   // Count enables; the upper prescaler is unused while chained
   ptc_prescale u_lpre (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .run      (l_run),
      .ext_src  (lc.ext_src),
      .prescale (lc.prescale),
      .ext_clk  (lower_ext_clk),
      .gate_in  (lower_gate),
      .gate_en  (lc.gate_en),
      .tick     (l_tick)
   );

   ptc_prescale u_upre (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .run      (u_run),
      .ext_src  (uc.ext_src),
      .prescale (uc.prescale),
      .ext_clk  (upper_ext_clk),
      .gate_in  (upper_gate),
      .gate_en  (uc.gate_en),
      .tick     (u_tick)
   );

   ///////////////////////////////////////////////////////////////////////
   // Period match detection
   assign l_match = (l_cnt_reg == l_per_reg);
   assign u_match = (u_cnt_reg == u_per_reg);
   assign m32     = l_match & u_match;

   // Lower counter: also the low word when chained, sharing its tick
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         l_cnt_reg <= `PTC_CNT_RST;
      end else if (lower_wr.cnt_we) begin
         l_cnt_reg <= lower_wr.wdata;
      end else if (l_tick) begin
         if (chain ? m32 : l_match) begin
            l_cnt_reg <= `PTC_CNT_RST;
         end else begin
            l_cnt_reg <= l_cnt_reg + 16'h0001;
         end
      end
   end

   // Upper counter: high word, stepped by low-word rollover when chained
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         u_cnt_reg <= `PTC_CNT_RST;
      end else if (upper_wr.cnt_we) begin
         u_cnt_reg <= upper_wr.wdata;
      end else if (chain) begin
         if (l_tick && m32) begin
            u_cnt_reg <= `PTC_CNT_RST;
         end else if (l_tick && l_cnt_reg == 16'hffff) begin
            u_cnt_reg <= u_cnt_reg + 16'h0001;
         end
      end else if (u_tick) begin
         if (u_match) begin
            u_cnt_reg <= `PTC_CNT_RST;
         end else begin
            u_cnt_reg <= u_cnt_reg + 16'h0001;
         end
      end
   end

   // Period words; chained, upper holds the high half of the period
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         l_per_reg <= `PTC_PER_RST;
         u_per_reg <= `PTC_PER_RST;
      end else begin
         if (lower_wr.per_we) begin
            l_per_reg <= lower_wr.wdata;
         end
         if (upper_wr.per_we) begin
            u_per_reg <= upper_wr.wdata;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // Interrupt flags; a set in the clearing cycle wins
   assign l_set = ~chain & l_tick & l_match;
   assign u_set = chain ? (l_tick & m32) : (u_tick & u_match);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         l_flag_reg <= 1'b0;
      end else if (l_set) begin
         l_flag_reg <= 1'b1;
      end else if (lower_flag_clr) begin
         l_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         u_flag_reg <= 1'b0;
      end else if (u_set) begin
         u_flag_reg <= 1'b1;
      end else if (pair_flag_clr) begin
         u_flag_reg <= 1'b0;
      end
   end

   // Outputs; no conversion trigger or shared time base leaves the pair
   assign lower_count         = l_cnt_reg;
   assign upper_count         = u_cnt_reg;
   assign lower_flag          = l_flag_reg;
   assign pair_interrupt_flag = u_flag_reg;
   assign lower_irq           = l_flag_reg & lower_int_enable;
   assign pair_irq            = u_flag_reg & pair_interrupt_enable;
endmodule

// [tb/ptc_timer_pair_chk.sv]
// Port checker for the paired cascade timer
`timescale 1ns/1ns
module ptc_timer_pair_chk
   import ptc_pkg::*;
(
   // Clock, reset, control
   input wire logic             sys_clk,
   input wire logic             sys_rst,
   input wire logic             cpu_idle,
   input wire logic [15:0]      lower_timer_control,
   input wire ptc_pkg::ptc_wr_t lower_wr,
   input wire ptc_pkg::ptc_wr_t upper_wr,
   input wire logic             lower_gate,
   input wire logic             lower_int_enable,
   input wire logic             pair_interrupt_enable,
   // Observed outputs
   input wire logic [15:0]      lower_count,
   input wire logic [15:0]      upper_count,
   input wire logic             lower_flag,
   input wire logic             pair_interrupt_flag,
   input wire logic             lower_irq,
   input wire logic             pair_irq
);
   import ptc_pkg::*;
   logic [15:0] c;
   logic        nowr;
   logic        run;
   logic        chn;
   // Free run at full rate with no write in flight
   assign c    = lower_timer_control;
   assign nowr = !lower_wr.cnt_we && !upper_wr.cnt_we && !lower_wr.per_we && !upper_wr.per_we;
   assign run  = c[15] && c[5:4] == 2'h0 && !c[1] && !c[6] && !(cpu_idle && c[13]) && nowr;
   assign chn  = c[3];
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   property p_lirq; lower_irq == (lower_flag && lower_int_enable); endproperty
   a_lirq: assert property (p_lirq) else $error("lower request mismatch");
   property p_pirq; pair_irq == (pair_interrupt_flag && pair_interrupt_enable); endproperty
   a_pirq: assert property (p_pirq) else $error("pair request mismatch");
   property p_step;
      $past(run) && run |=> lower_count == $past(lower_count) + 16'h0001 || lower_count == 16'h0000;
   endproperty
   a_step: assert property (p_step) else $error("low word step wrong");
   property p_roll;
      chn && $past(run) && run && lower_count == 16'hffff |=> lower_count == 16'h0000
         && (upper_count == $past(upper_count) + 16'h0001 || upper_count == 16'h0000);
   endproperty
   a_roll: assert property (p_roll) else $error("high word did not step");
   property p_halt;
      chn && !c[15] && !$past(c[15]) && nowr |=> $stable(lower_count) && $stable(upper_count);
   endproperty
   a_halt: assert property (p_halt) else $error("counted while chained off");
   property p_gate; chn && c[15] && c[6] && !lower_gate && nowr |=> $stable(lower_count); endproperty
   a_gate: assert property (p_gate) else $error("counted with gate low");
   property p_nolf; chn && $past(chn) |-> !$rose(lower_flag); endproperty
   a_nolf: assert property (p_nolf) else $error("lower flag set while chained");
   property p_pflag;
      $rose(pair_interrupt_flag) |-> upper_count == 16'h0000 && (!$past(chn) || lower_count == 16'h0000);
   endproperty
   a_pflag: assert property (p_pflag) else $error("pair flag without wrap");
   property p_lflag; $rose(lower_flag) |-> lower_count == 16'h0000; endproperty
   a_lflag: assert property (p_lflag) else $error("lower flag without wrap");
   // Main scenarios reached
   c_pair: cover property ($rose(pair_interrupt_flag));
   c_lower: cover property ($rose(lower_flag));
   c_roll: cover property (chn && run && lower_count == 16'hffff);
endmodule

// [tb/tb.sv]
// Self-checking bench for the paired cascade timer
`timescale 1ns/1ns
module tb;
   import ptc_pkg::*;
   logic        sys_clk, sys_rst, cpu_idle, lower_ext_clk, lower_gate, upper_ext_clk, upper_gate;
   logic        lower_flag_clr, pair_flag_clr, lower_int_enable, pair_interrupt_enable;
   logic [15:0] lower_timer_control, upper_timer_control, lower_count, upper_count;
   ptc_wr_t     lower_wr, upper_wr;
   logic        lower_flag, pair_interrupt_flag, lower_irq, pair_irq;
   int          num_errors, check_count;
   ptc_timer_pair i_ptc_timer_pair (.sys_clk, .sys_rst, .cpu_idle, .lower_timer_control,
      .upper_timer_control, .lower_wr, .upper_wr, .lower_ext_clk, .lower_gate, .upper_ext_clk,
      .upper_gate, .lower_flag_clr, .pair_flag_clr, .lower_int_enable, .pair_interrupt_enable,
      .lower_count, .upper_count, .lower_flag, .pair_interrupt_flag, .lower_irq, .pair_irq);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: expected %h got %h", $time, exp, got);
      end
   endtask
   task automatic clk(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // One-cycle count or period write
   task automatic wr(input logic up, input logic per, input logic [15:0] v);
      ptc_wr_t w;
      w = '{cnt_we: !per, per_we: per, wdata: v};
      if (up) upper_wr <= w;
      else lower_wr <= w;
      clk(1);
      upper_wr <= '0;
      lower_wr <= '0;
      clk(1);
   endtask
   // Bounded wait; running out ends the run
   task automatic wait_flag(input logic pair);
      int i;
      for (i = 0; i < 200 && (pair ? pair_interrupt_flag : lower_flag) !== 1'b1; i++) clk(1);
      if (i == 200) begin
         num_errors++;
         results();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_sixteen();
      wr(0, 1, 16'h0004);
      lower_timer_control <= 16'h8000;  // Lower on, internal, ratio 1
      upper_timer_control <= 16'h8002;  // Upper on, external edges
      wait_flag(0);
      chk(16'h0000, lower_count);
      chk(16'h0000, {15'h0, lower_irq});
      lower_int_enable <= 1'b1;
      repeat (3) begin
         upper_ext_clk <= 1'b1;
         clk(2);
         upper_ext_clk <= 1'b0;
         clk(2);
      end
      chk(16'h0003, upper_count);
      chk(16'h0001, {15'h0, lower_irq});
      lower_timer_control <= 16'h0008;  // Chained but off; upper word now ignored
      lower_flag_clr <= 1'b1;
      clk(1);
      lower_flag_clr <= 1'b0;
      clk(2);
      chk(16'h0000, {15'h0, lower_flag});
      $display("test sixteen done");
   endtask
   task automatic t_chain();
      upper_timer_control <= 16'h8000;
      pair_interrupt_enable <= 1'b1;
      wr(0, 0, 16'hfffd);
      wr(1, 0, 16'h0000);
      wr(0, 1, 16'h0001);
      wr(1, 1, 16'h0001);
      clk(4);
      chk(16'h0000, upper_count);
      lower_timer_control <= 16'h8008;
      wait_flag(1);
      chk(16'h0000, upper_count | lower_count);
      chk(16'h0002, {14'h0, pair_irq, lower_flag});
      $display("test chain done");
   endtask
   task automatic t_gate();
      lower_timer_control <= 16'h0048;
      upper_gate <= 1'b1;
      wr(0, 0, 16'h0010);
      wr(1, 0, 16'h0000);
      lower_timer_control <= 16'h8048;
      clk(6);
      chk(16'h0010, lower_count);
      lower_gate <= 1'b1;
      clk(6);
      lower_gate <= 1'b0;
      clk(3);
      chk(16'h0016, lower_count);
      pair_flag_clr <= 1'b1;
      clk(1);
      pair_flag_clr <= 1'b0;
      clk(2);
      chk(16'h0000, {15'h0, pair_interrupt_flag});
      $display("test gate done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Free-running system clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // Reset, then the scenarios in turn
   initial begin
      {sys_rst, cpu_idle, lower_ext_clk, lower_gate, upper_ext_clk, upper_gate} = 6'h20;
      {lower_flag_clr, pair_flag_clr, lower_int_enable, pair_interrupt_enable} = 4'h0;
      lower_timer_control = 16'h0000;
      upper_timer_control = 16'h0000;
      lower_wr = '0;
      upper_wr = '0;
      num_errors = 0;
      check_count = 0;
      clk(12);
      sys_rst <= 1'b0;
      clk(1);
      chk(16'h0000, lower_count | upper_count);
      chk(16'h0000, {12'h0, lower_flag, pair_interrupt_flag, lower_irq, pair_irq});
      t_sixteen();
      t_chain();
      t_gate();
      results();
   end
endmodule
bind ptc_timer_pair ptc_timer_pair_chk i_chk (.sys_clk, .sys_rst, .cpu_idle, .lower_timer_control,
   .lower_wr, .upper_wr, .lower_gate, .lower_int_enable, .pair_interrupt_enable, .lower_count,
   .upper_count, .lower_flag, .pair_interrupt_flag, .lower_irq, .pair_irq);
